// ### hdl/priority_arbiter_defines.vh
/*
 * Constants for the priority interrupt arbiter: vector numbers, levels,
 * source indices and exception-entry step counts.
 * Assumes inclusion by bare name from the design files only.
 */
`ifndef PRIORITY_ARBITER_DEFINES_VH
`define PRIORITY_ARBITER_DEFINES_VH

// Source count and levels
`define NUM_SRC          29
`define LEVEL_W          4
`define LEVEL_MAX        4'hF
`define LEVEL_ZERO       4'h0
`define LEVEL_RESET      16'h0000
`define NMI_LEVEL        5'h10

// Vector numbers of all sources (first vector of the pin and serial groups)
`define VEC_BREAK        8'h0C
`define VEC_NMI          8'h0B
`define VEC_DEBUG        8'h0D
`define VEC_EXT_LO       8'h40
`define VEC_EXT_HI       8'h50
`define VEC_WATCHDOG     8'h54
`define VEC_CMT0         8'h56
`define VEC_CMT1         8'h57
`define VEC_SERIAL       8'h58
`define VEC_HOST         8'h64
`define VEC_HOST_BOOT    8'h65

// Source index ranges (index order is the fixed default order)
`define IDX_BREAK        0
`define IDX_NMI          1
`define IDX_DEBUG        2
`define IDX_EXT          3
`define IDX_WATCHDOG     11
`define IDX_CMT0         12
`define IDX_CMT1         13
`define IDX_SERIAL       14
`define IDX_HOST         26
`define IDX_HOST_BOOT    27
`define IDX_NONE         28

// Vector table address is vector number times four
`define VEC_ADDR_SHIFT   2

// Exception entry steps
`define ENTRY_STEPS      4

`endif

// ### hdl/level_select.v
/*
 * Picks the highest-level request among all pending sources; equal levels
 * resolve to the lower index, which is the fixed default order.
 * Assumes level and pending vectors are flat and same-clock.
 */
`timescale 1ns/100ps
`default_nettype none

`include "priority_arbiter_defines.vh"

module level_select #(
    parameter N = 28
) (
    // Requests
    input  wire [N-1:0]   pend,
    input  wire [5*N-1:0] levels,
    // Winner
    output reg  [4:0]     win_level,
    output reg  [4:0]     win_index,
    output reg            win_valid
);

    integer i;
    reg [4:0] lv;

    always @* begin
        win_level = 5'h00;
        win_index = 5'h00;
        win_valid = 1'b0;
        lv        = 5'h00;
        // Scan high index down so greater or equal wins; ties keep low index
        for (i = N - 1; i >= 0; i = i - 1) begin
            lv = levels[5*i +: 5];
            if (pend[i] && lv != 5'h00 && lv >= win_level) begin // [RQ9] [RQ10] [RQ5] [RQ20]
                win_level = lv;
                win_index = i[4:0];
                win_valid = 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ### hdl/priority_arbiter.v
/*
 * Priority interrupt arbiter with vectoring and exception-entry sequencer.
 * Assumes the CPU core samples cpu_req in decode, answers with decode_ack,
 * performs stack writes on stack_wr/stack_done and vector reads on
 * vec_rd/vec_done. Request inputs arrive on clk from on-chip logic.
 */
//
// How it works
// [RQ1] Each peripheral source owns vector, level 0-15
// [RQ2] Peripheral acceptance loads mask with its level
// [RQ3] Breakpoint fixed 15, edge latched, mask 15
// [RQ4] Debug interrupt fixed 15, edge latched, mask 15
// [RQ5] Shared field: smaller vector number wins
// [RQ6] All priority fields reset to zero
// [RQ7] Fixed vector numbers per source
// [RQ8] Table address derived from vector number
// [RQ9] Highest programmed level wins the round
// [RQ10] Equal levels follow fixed default order
// [RQ11] Forward only when level exceeds mask
// [RQ12] CPU samples request in decode stage
// [RQ13] Status and PC pushed before vector
// [RQ14] Accepted level written into mask field
// [RQ15] Branch to handler, non-delayed
// [RQ16] Edge requests pend until accepted or reset
// [RQ17] Software cancels pending external pin requests
// [RQ18] Pushed PC is the return address
// [RQ19] Non-maskable pin level 16, always accepted
// [RQ20] Level zero source is masked
// [RQ21] Levels 4-bit plain binary
//
`timescale 1ns/100ps
`default_nettype none

`include "priority_arbiter_defines.vh"

module priority_arbiter #(
    parameter ADDR_W = 32
) (
    // Clock and reset
    input  wire              clk,
    input  wire              rst_n,
    input  wire              debug_reset,
    // Priority fields, four 4-bit levels per register
    input  wire [15:0]       priority_reg_a,
    input  wire [15:0]       priority_reg_b,
    input  wire [15:0]       priority_reg_c,
    input  wire [15:0]       priority_reg_d,
    input  wire [15:0]       priority_reg_e,
    input  wire              priority_we,
    // Fixed sources
    input  wire              breakpoint_unit,
    input  wire              nmi_edge,
    input  wire              debug_serial_port,
    // External pins, already edge or level qualified
    input  wire [7:0]        ext_pin_int,
    input  wire [7:0]        ext_pin_is_edge,
    input  wire [7:0]        ext_pin_status_reg,
    input  wire              ext_pin_status_we,
    // Peripheral requests (levels)
    input  wire              watchdog_interval_int,
    input  wire              compare_match_int_0,
    input  wire              compare_match_int_1,
    input  wire [11:0]       serial_int,
    input  wire              host_port_int,
    input  wire              host_port_boot_int,
    // CPU core
    input  wire [3:0]        cpu_mask_level,
    input  wire              decode_ack,
    input  wire [ADDR_W-1:0] next_pc,
    input  wire [31:0]       cpu_status_word,
    input  wire              stack_done,
    input  wire              vec_done,
    input  wire [ADDR_W-1:0] vec_data,
    // Outputs to CPU core
    output reg               cpu_req,
    output reg  [7:0]        cpu_vector,
    output reg               stack_wr,
    output reg  [31:0]       stack_data,
    output reg               vec_rd,
    output reg  [ADDR_W-1:0] vec_addr,
    output reg               mask_we,
    output reg  [3:0]        mask_value,
    output reg               branch,
    output reg  [ADDR_W-1:0] branch_addr,
    output reg  [7:0]        ext_pin_pending
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function [7:0] vector_of;
        input [4:0] idx;
        begin
            if (idx == `IDX_BREAK)            vector_of = `VEC_BREAK; // [RQ7]
            else if (idx == `IDX_NMI)         vector_of = `VEC_NMI;
            else if (idx == `IDX_DEBUG)       vector_of = `VEC_DEBUG;
            else if (idx < `IDX_EXT + 4)      vector_of = `VEC_EXT_LO + {3'h0, idx - 5'd3};
            else if (idx < `IDX_WATCHDOG)     vector_of = `VEC_EXT_HI + {3'h0, idx - 5'd7};
            else if (idx == `IDX_WATCHDOG)    vector_of = `VEC_WATCHDOG;
            else if (idx == `IDX_CMT0)        vector_of = `VEC_CMT0;
            else if (idx == `IDX_CMT1)        vector_of = `VEC_CMT1;
            else if (idx < `IDX_HOST)         vector_of = `VEC_SERIAL + {3'h0, idx - 5'd14}; // [RQ1]
            else if (idx == `IDX_HOST)        vector_of = `VEC_HOST;
            else                              vector_of = `VEC_HOST_BOOT;
        end
    endfunction

    function [4:0] field;
        input [15:0] r;
        input [1:0]  pos;
        begin
            // Field 3 sits in bits 15..12, plain binary
            field = {1'b0, r[4*pos +: 4]}; // [RQ21]
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Priority levels held locally so reset forces them to zero

    reg [15:0] lvl_a, lvl_b, lvl_c, lvl_d, lvl_e;

    always @(posedge clk) begin
        if (!rst_n) begin
            lvl_a <= `LEVEL_RESET; // [RQ6]
            lvl_b <= `LEVEL_RESET;
            lvl_c <= `LEVEL_RESET;
            lvl_d <= `LEVEL_RESET;
            lvl_e <= `LEVEL_RESET;
        end else if (priority_we) begin
            lvl_a <= priority_reg_a;
            lvl_b <= priority_reg_b;
            lvl_c <= priority_reg_c;
            lvl_d <= priority_reg_d;
            lvl_e <= priority_reg_e;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge-latched requests

    reg        brk_prev, dbg_prev;
    reg        brk_pend, nmi_pend, dbg_pend;
    reg  [7:0] ext_prev;
    wire       accept;
    reg  [4:0] acc_index;
    wire [7:0] ext_rise = ext_pin_int & ~ext_prev;
    integer    k;

    always @(posedge clk) begin
        if (!rst_n || debug_reset) begin
            brk_prev        <= 1'b0;
            dbg_prev        <= 1'b0;
            ext_prev        <= 8'h00;
            brk_pend        <= 1'b0; // [RQ16]
            nmi_pend        <= 1'b0;
            dbg_pend        <= 1'b0;
            ext_pin_pending <= 8'h00;
        end else begin
            brk_prev <= breakpoint_unit;
            dbg_prev <= debug_serial_port;
            ext_prev <= ext_pin_int;
            // New edge wins over the acceptance clear
            if (breakpoint_unit && !brk_prev)
                brk_pend <= 1'b1; // [RQ3]
            else if (accept && acc_index == `IDX_BREAK)
                brk_pend <= 1'b0;
            if (nmi_edge)
                nmi_pend <= 1'b1;
            else if (accept && acc_index == `IDX_NMI)
                nmi_pend <= 1'b0;
            if (debug_serial_port && !dbg_prev)
                dbg_pend <= 1'b1; // [RQ4]
            else if (accept && acc_index == `IDX_DEBUG)
                dbg_pend <= 1'b0;
            for (k = 0; k < 8; k = k + 1) begin
                if (!ext_pin_is_edge[k])
                    ext_pin_pending[k] <= ext_pin_int[k];
                else if (ext_rise[k])
                    ext_pin_pending[k] <= 1'b1; // [RQ16]
                else if (ext_pin_status_we && !ext_pin_status_reg[k])
                    ext_pin_pending[k] <= 1'b0; // [RQ17]
                else if (accept && acc_index == `IDX_EXT + k)
                    ext_pin_pending[k] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request and level vectors, index order equals default order

    wire [27:0] pend = {host_port_boot_int, host_port_int, serial_int,
                        compare_match_int_1, compare_match_int_0,
                        watchdog_interval_int, ext_pin_pending,
                        dbg_pend, nmi_pend, brk_pend};

    // Serial channels share one field for all four of their sources
    wire [139:0] levels = {
        field(lvl_e, 2'd2), field(lvl_e, 2'd3),                  // [RQ1]
        {4{field(lvl_d, 2'd1)}}, {4{field(lvl_d, 2'd2)}},
        {4{field(lvl_d, 2'd3)}},                                 // [RQ5]
        field(lvl_c, 2'd0), field(lvl_c, 2'd1), field(lvl_c, 2'd3),
        field(lvl_b, 2'd0), field(lvl_b, 2'd1), field(lvl_b, 2'd2),
        field(lvl_b, 2'd3), field(lvl_a, 2'd0), field(lvl_a, 2'd1),
        field(lvl_a, 2'd2), field(lvl_a, 2'd3),
        {1'b0, `LEVEL_MAX}, `NMI_LEVEL, {1'b0, `LEVEL_MAX}       // [RQ3] [RQ4] [RQ19]
    };

    wire [4:0] win_level;
    wire [4:0] win_index;
    wire       win_valid;

    level_select #(
        .N(28)
    ) u_select (
        .pend      (pend),
        .levels    (levels),
        .win_level (win_level),
        .win_index (win_index),
        .win_valid (win_valid)
    );

    // Non-maskable level 16 always exceeds any 4-bit mask
    wire fwd = win_valid && (win_level > {1'b0, cpu_mask_level}); // [RQ11] [RQ19]

    ////////////////////////////////////////////////////////////////////////
    // Exception entry sequencer

    localparam [5:0] S_IDLE   = 6'h01;
    localparam [5:0] S_PUSHSR = 6'h02;
    localparam [5:0] S_PUSHPC = 6'h04;
    localparam [5:0] S_MASK   = 6'h08;
    localparam [5:0] S_VEC    = 6'h10;
    localparam [5:0] S_BRANCH = 6'h20;

    reg [5:0]        state;
    reg [4:0]        acc_level;
    reg [ADDR_W-1:0] ret_pc;

    assign accept = (state == S_IDLE) && cpu_req && decode_ack; // [RQ12]

    always @(posedge clk) begin
        if (!rst_n) begin
            state       <= S_IDLE;
            cpu_req     <= 1'b0;
            cpu_vector  <= 8'h00;
            acc_index   <= `IDX_NONE;
            acc_level   <= 5'h00;
            ret_pc      <= {ADDR_W{1'b0}};
            stack_wr    <= 1'b0;
            stack_data  <= 32'h00000000;
            vec_rd      <= 1'b0;
            vec_addr    <= {ADDR_W{1'b0}};
            mask_we     <= 1'b0;
            mask_value  <= 4'h0;
            branch      <= 1'b0;
            branch_addr <= {ADDR_W{1'b0}};
        end else begin
            mask_we <= 1'b0;
            branch  <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (accept) begin
                        // Winner is frozen at decode so a late arrival cannot swap vector
                        cpu_req    <= 1'b0;
                        ret_pc     <= next_pc; // [RQ18]
                        stack_wr   <= 1'b1;
                        stack_data <= cpu_status_word; // [RQ13]
                        state      <= S_PUSHSR;
                    end else begin
                        cpu_req    <= fwd; // [RQ11]
                        cpu_vector <= vector_of(win_index); // [RQ7]
                        acc_index  <= win_index;
                        acc_level  <= win_level;
                    end
                end
                S_PUSHSR: begin
                    if (stack_done) begin
                        stack_data <= ret_pc[31:0]; // [RQ13] [RQ18]
                        state      <= S_PUSHPC;
                    end
                end
                S_PUSHPC: begin
                    if (stack_done) begin
                        stack_wr <= 1'b0;
                        state    <= S_MASK;
                    end
                end
                S_MASK: begin
                    mask_we <= 1'b1;
                    // Level 16 saturates to 15 in the 4-bit field
                    mask_value <= acc_level[4] ? `LEVEL_MAX : acc_level[3:0]; // [RQ2] [RQ14]
                    vec_rd   <= 1'b1;
                    vec_addr <= {{(ADDR_W-8){1'b0}}, cpu_vector} << `VEC_ADDR_SHIFT; // [RQ8]
                    state    <= S_VEC;
                end
                S_VEC: begin
                    if (vec_done) begin
                        vec_rd      <= 1'b0;
                        branch      <= 1'b1; // [RQ15]
                        branch_addr <= vec_data; // [RQ8]
                        state       <= S_BRANCH;
                    end
                end
                S_BRANCH: begin
                    acc_index <= `IDX_NONE;
                    state     <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

endmodule

`default_nettype wire

// ### sim/priority_arbiter_assertions.sv
/* Checker for the priority arbiter: entry order, vectoring and mask rules.
   Assumes it is bound to priority_arbiter, one clock, synchronous reset. */
`timescale 1ns/100ps
`default_nettype none
module priority_arbiter_assertions #(parameter ADDR_W = 32) (
    // Clock, reset and CPU side
    input wire logic              clk, rst_n, decode_ack, stack_done, vec_done,
    input wire logic [3:0]        cpu_mask_level,
    input wire logic [ADDR_W-1:0] next_pc, vec_data,
    input wire logic [31:0]       cpu_status_word,
    // Arbiter outputs
    input wire logic              cpu_req, stack_wr, vec_rd, mask_we, branch,
    input wire logic [7:0]        cpu_vector,
    input wire logic [31:0]       stack_data,
    input wire logic [ADDR_W-1:0] vec_addr, branch_addr,
    input wire logic [3:0]        mask_value
);
    // Accepted request, held through the entry
    logic [7:0]        acc_vec;
    logic [3:0]        acc_mask;
    logic [ADDR_W-1:0] acc_pc;
    always @(posedge clk) begin
        if (!rst_n) begin
            acc_vec <= 8'h00;
            acc_mask <= 4'h0;
            acc_pc <= {ADDR_W{1'b0}};
        end else if (decode_ack && cpu_req) begin
            acc_vec <= cpu_vector;
            acc_mask <= cpu_mask_level;
            acc_pc <= next_pc;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_stack_first: assert property (decode_ack && cpu_req |=>
        stack_wr && !cpu_req && stack_data == $past(cpu_status_word)) else $error("bad SR push");
    chk_pc_push: assert property ($past(stack_done) && stack_wr |->
        stack_data == acc_pc) else $error("bad PC push");
    chk_order_mask: assert property ($rose(vec_rd) |-> mask_we && !stack_wr)
        else $error("mask write out of order");
    chk_vec_addr: assert property (vec_rd |-> vec_addr == {acc_vec, 2'b00})
        else $error("bad vector address");
    chk_branch_target: assert property (branch |-> $past(vec_done) &&
        branch_addr == $past(vec_data)) else $error("bad branch");
    chk_branch_once: assert property (branch |=> !branch) else $error("branch too long");
    chk_mask_once: assert property (mask_we |=> !mask_we) else $error("mask_we too long");
    chk_mask_gate: assert property (mask_we |-> mask_value > acc_mask ||
        acc_vec == 8'h0B) else $error("accepted at or below mask");
    chk_fixed_mask: assert property (mask_we && acc_vec inside {8'h0B, 8'h0C, 8'h0D} |->
        mask_value == 4'hF) else $error("fixed source mask not 15");
    chk_vector_legal: assert property (cpu_req |-> cpu_vector inside {[8'h0B:8'h0D],
        [8'h40:8'h43], [8'h50:8'h54], [8'h56:8'h65]}) else $error("illegal vector");
    cover property (decode_ack && cpu_req);
    cover property (branch);
    cover property (mask_we && acc_vec == 8'h0B);
endmodule
bind priority_arbiter priority_arbiter_assertions #(.ADDR_W(ADDR_W)) chk (.clk, .rst_n,
    .decode_ack, .stack_done, .vec_done, .cpu_mask_level, .next_pc, .vec_data,
    .cpu_status_word, .cpu_req, .stack_wr, .vec_rd, .mask_we, .branch, .cpu_vector,
    .stack_data, .vec_addr, .branch_addr, .mask_value);
`default_nettype wire

// ### sim/cpu_core_model.sv
/* CPU core model answering the arbiter's request, stack and vector handshakes.
   Assumes one clock; each answer comes after slow idle cycles. */
`timescale 1ns/100ps
`default_nettype none
module cpu_core_model (
    // Clock, reset and pacing
    input  wire logic        clk, rst_n, ack_en,
    input  wire logic [1:0]  slow,
    // From the arbiter
    input  wire logic        cpu_req, stack_wr, vec_rd, mask_we,
    input  wire logic [3:0]  mask_value,
    input  wire logic [31:0] stack_data, vec_addr,
    // Answers and what was seen
    output logic             decode_ack, stack_done, vec_done,
    output logic [31:0]      vec_data, seen_sr, seen_pc,
    output logic [3:0]       seen_mask
);
    logic [1:0] cnt;
    logic       second;
    wire        quiet = decode_ack | stack_done | vec_done | !(stack_wr | vec_rd | cpu_req & ack_en);
    ////////////////////////////////////////////////////////////////////////////////
    // Falling edge keeps answers clear of the sampling edge
    always @(negedge clk) begin
        decode_ack <= 1'b0;
        stack_done <= 1'b0;
        vec_done <= 1'b0;
        // Table word hidden outside its answer cycle
        vec_data <= ~(vec_addr + 32'h0000_1000);
        if (mask_we) seen_mask <= mask_value;
        if (!rst_n || quiet) begin
            cnt <= 2'h0;
            if (!rst_n) second <= 1'b0;
        end else if (cnt != slow) cnt <= cnt + 2'h1;
        else begin
            cnt <= 2'h0;
            if (stack_wr) begin
                stack_done <= 1'b1;
                second <= !second;
                if (second) seen_pc <= stack_data;
                else seen_sr <= stack_data;
            end else if (vec_rd) begin
                vec_done <= 1'b1;
                vec_data <= vec_addr + 32'h0000_1000;
            end else decode_ack <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
/* Self-checking bench for priority_arbiter against a reference winner model.
   Assumes the CPU core model and the bound checker are compiled alongside. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, rst_n = 1'b0, debug_reset = 1'b0, priority_we = 1'b0, nmi_edge = 1'b0;
    logic breakpoint_unit = 1'b0, debug_serial_port = 1'b0, ext_pin_status_we = 1'b0;
    logic [15:0] priority_reg_a = 16'h0000, priority_reg_b = 16'h0000, priority_reg_c = 16'h0000;
    logic [15:0] priority_reg_d = 16'h0000, priority_reg_e = 16'h0000;
    logic [7:0]  ext_pin_int = 8'h00, ext_pin_is_edge = 8'h00, ext_pin_status_reg = 8'hFF;
    logic watchdog_interval_int = 1'b0, compare_match_int_0 = 1'b0, compare_match_int_1 = 1'b0;
    logic host_port_int = 1'b0, host_port_boot_int = 1'b0, ack_en = 1'b0;
    logic [11:0] serial_int = 12'h000;
    logic [3:0]  cpu_mask_level = 4'h0, mask_value, seen_mask;
    logic [1:0]  slow = 2'h0;
    logic [31:0] next_pc = 32'h0000_0000, cpu_status_word = 32'h0000_0000, vec_data, stack_data;
    logic [31:0] vec_addr, branch_addr, seen_sr, seen_pc, s = 32'h0001_655F;
    logic [7:0]  cpu_vector, ext_pin_pending, ev;
    logic        decode_ack, stack_done, vec_done, cpu_req, stack_wr, vec_rd, mask_we, branch;
    logic [27:0] r;
    logic [4:0]  el;
    int          fail_count = 0, n_compared = 0, i, j, k;
    always #5 clk = ~clk;
    priority_arbiter dut (.clk, .rst_n, .debug_reset, .priority_reg_a, .priority_reg_b,
        .priority_reg_c, .priority_reg_d, .priority_reg_e, .priority_we, .breakpoint_unit,
        .nmi_edge, .debug_serial_port, .ext_pin_int, .ext_pin_is_edge, .ext_pin_status_reg,
        .ext_pin_status_we, .watchdog_interval_int, .compare_match_int_0, .compare_match_int_1,
        .serial_int, .host_port_int, .host_port_boot_int, .cpu_mask_level, .decode_ack,
        .next_pc, .cpu_status_word, .stack_done, .vec_done, .vec_data, .cpu_req, .cpu_vector,
        .stack_wr, .stack_data, .vec_rd, .vec_addr, .mask_we, .mask_value, .branch,
        .branch_addr, .ext_pin_pending);
    cpu_core_model core (.clk, .rst_n, .ack_en, .slow, .cpu_req, .stack_wr, .vec_rd, .mask_we,
        .mask_value, .stack_data, .vec_addr, .decode_ack, .stack_done, .vec_done, .vec_data,
        .seen_sr, .seen_pc, .seen_mask);
    ////////////////////////////////////////////////////////////////////////////////
    function automatic [31:0] nx(input [31:0] v);
        for (int b = 0; b < 32; b++) v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
        return v;
    endfunction
    function automatic [3:0] fld(input [15:0] q, input int p);
        return q[15 - 4 * p -: 4];
    endfunction
    // Index order is the fixed default order
    function automatic [4:0] lvl(input int n);
        if (n == 1) return 5'h10;
        if (n < 3) return 5'h0F;
        if (n < 7) return fld(priority_reg_a, n - 3);
        if (n < 11) return fld(priority_reg_b, n - 7);
        if (n < 14) return fld(priority_reg_c, n == 11 ? 0 : n - 10);
        if (n < 26) return fld(priority_reg_d, (n - 14) / 4);
        return fld(priority_reg_e, n - 26);
    endfunction
    function automatic [7:0] vec(input int n);
        if (n < 3) return n == 0 ? 8'h0C : n == 1 ? 8'h0B : 8'h0D;
        return n < 7 ? 8'h3D + n : n < 11 ? 8'h49 + n : n == 11 ? 8'h54 : 8'h4A + n;
    endfunction
    task automatic expect_win;
        ev = 8'h00;
        el = 5'h00;
        for (int q = 0; q < 28; q++) if (r[q] && lvl(q) > el) {ev, el} = {vec(q), lvl(q)};
    endtask
    task drive;
        {host_port_boot_int, host_port_int, serial_int, compare_match_int_1} = r[27:13];
        {compare_match_int_0, watchdog_interval_int, ext_pin_int} = r[12:3];
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task settle;
        repeat (4) @(negedge clk);
    endtask
    task print_verdict;
        $display("compared %0d, mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task accept(input [7:0] v, input [3:0] m);
        s = nx(s);
        {next_pc, cpu_status_word, slow, ack_en} = {s, ~s, s[1:0], 1'b1};
        for (k = 0; k < 40 && branch !== 1'b1; k++) @(negedge clk);
        ack_en = 1'b0;
        check(k < 40, 1);
        if (k == 40) print_verdict;
        check(branch_addr, {v, 2'b00} + 32'h0000_1000);
        check(seen_sr, ~next_pc);
        check(seen_pc, next_pc);
        check(seen_mask, m);
    endtask
    task pulse;
        if (j) debug_serial_port = 1'b1;
        else breakpoint_unit = 1'b1;
        repeat (2) @(negedge clk);
        {debug_serial_port, breakpoint_unit} = 2'b00;
        settle;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        {priority_reg_a, priority_reg_b, priority_reg_c, priority_reg_d, priority_reg_e} = '1;
        r = 28'hFFFFFF8;
        drive;
        settle;
        check({cpu_req, stack_wr, vec_rd}, 0);
        $display("test reset_levels done");
        for (i = 0; i < 60; i++) begin
            s = nx(s);
            {priority_reg_a, priority_reg_b} = s;
            s = nx(s);
            {priority_reg_c, priority_reg_d} = s;
            s = nx(s);
            {priority_reg_e, cpu_mask_level} = s[19:0];
            r = {s[24:0] & (s[25] ? 25'h1FFFFFF : s[31:7]), 3'b000};
            priority_we = 1'b1;
            drive;
            @(negedge clk) priority_we = 1'b0;
            settle;
            expect_win;
            check(cpu_req, el > cpu_mask_level);
            if (el > cpu_mask_level) begin
                check(cpu_vector, ev);
                accept(ev, el[3:0]);
            end
            r = 28'h0;
            drive;
            settle;
        end
        $display("test random_arbitration done");
        for (j = 0; j < 2; j++) begin
            ev = j ? 8'h0D : 8'h0C;
            cpu_mask_level = 4'hE;
            pulse;
            check(cpu_vector, ev);
            accept(ev, 4'hF);
            cpu_mask_level = 4'hF;
            pulse;
            check(cpu_req, 0);
            cpu_mask_level = 4'h0;
            settle;
            check(cpu_req, 1);
            accept(ev, 4'hF);
            cpu_mask_level = 4'hF;
            pulse;
            debug_reset = 1'b1;
            @(negedge clk) {debug_reset, cpu_mask_level} = 5'h00;
            settle;
            check(cpu_req, 0);
        end
        $display("test edge_sources done");
        cpu_mask_level = 4'hF;
        nmi_edge = 1'b1;
        @(negedge clk) nmi_edge = 1'b0;
        settle;
        check(cpu_vector, 8'h0B);
        accept(8'h0B, 4'hF);
        $display("test nmi done");
        {priority_reg_a, priority_we, ext_pin_is_edge, ext_pin_int} = {16'h0050, 1'b1, 16'h0404};
        repeat (2) @(negedge clk) priority_we = 1'b0;
        ext_pin_int = 8'h00;
        settle;
        check(ext_pin_pending, 8'h04);
        {ext_pin_status_reg, ext_pin_status_we} = {8'hFB, 1'b1};
        @(negedge clk) {ext_pin_status_we, cpu_mask_level} = 5'h00;
        settle;
        check({cpu_req, ext_pin_pending}, 0);
        $display("test pin_cancel done");
        print_verdict;
    end
endmodule
`default_nettype wire
